/* File: shared/sjt_pkg.sv */
// constants and types shared by the boundary-scan test port of the sram
//
// Overview of operation
// (RULE_01) code 000 runs external test with the boundary-scan chain as serial path
// (RULE_02) code 001 puts the 32-bit identification register between tdi and tdo
// (RULE_03) code 010 floats the output bus and selects the boundary-scan chain
// (RULE_04) code 100 runs sample/preload with the boundary-scan chain as serial path
// (RULE_05) code 111 puts the one-bit bypass register between tdi and tdo
// (RULE_06) the tester never loads codes 011, 101 or 110; the testbench loads all three and expects bypass
// (RULE_07) identification: revision 31:29, part configuration 28:12, maker code 11:1
// (RULE_08) identification bit 0 always captures and shifts out as one
// (RULE_09) density field: 001 is 18 Mb, 010 is 36 Mb, 011 is 72 Mb
// (RULE_10) word width field: 11 for 36-bit words, 10 for 18-bit words
// (RULE_11) latency flag is one only for a read latency of 2.5 cycles
// (RULE_12) flags: burst of four, separate data ports, on-die termination present
// (RULE_13) flags: enhanced generation, and four-word separate-port family
// (RULE_14) 109 cells: 108 ball cells in exit order plus internal cell 109
// (RULE_15) cells of unconnected balls are don't-care; the tester ignores them; the testbench compares all cells
// (RULE_16) identification instruction is loaded at reset and in test-logic-reset
// (RULE_17) during external test cell 109 high drives the data bus, low floats it
// (RULE_18) bypass is a single stage between tdi and tdo
// (RULE_19) tap state machine follows the standard, stepped on tck rising edges by tms
// (RULE_20) tdo changes on tck falling edges and is driven only in shift states
package sjt_pkg;

  // ==========================================================================
  // instruction register
  localparam int unsigned IR_LEN = 3;
  localparam logic [2:0] INS_EXTEST   = 3'h0;
  localparam logic [2:0] INS_IDCODE   = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE   = 3'h4;
  localparam logic [2:0] INS_BYPASS   = 3'h7;
  localparam logic [2:0] IR_CAPTURE   = 3'h1;

  // ==========================================================================
  // boundary-scan chain; cell n of the exit order is bit n-1, bit 0 nearest tdo
  localparam int unsigned BSR_LEN    = 109;
  localparam int unsigned BALL_CELLS = 108;
  localparam int unsigned QEN_CELL   = 108;
  localparam logic        QEN_RESET  = 1'b0;

  // ==========================================================================
  // identification register fields
  localparam int unsigned ID_LEN = 32;
  localparam logic [2:0]  ID_REVISION    = 3'h0;
  localparam logic [2:0]  DENS_18MB      = 3'h1;
  localparam logic [2:0]  DENS_36MB      = 3'h2;
  localparam logic [2:0]  DENS_72MB      = 3'h3;
  localparam logic [1:0]  WIDTH_X36      = 2'h3;
  localparam logic [1:0]  WIDTH_X18      = 2'h2;
  localparam logic [2:0]  density_field    = DENS_18MB;
  localparam logic [1:0]  word_width_field = WIDTH_X36;
  localparam logic        read_latency     = 1'b0;
  localparam logic        ENHANCED_GEN   = 1'b1;
  localparam logic        FOUR_WORD_FAM  = 1'b0;
  localparam logic        BURST_OF_FOUR  = 1'b1;
  localparam logic        SEPARATE_IO    = 1'b0;
  localparam logic        on_die_termination = 1'b0;
  // maker code value is arbitrary
  localparam logic [10:0] MAKER_CODE     = 11'h2a6;
  localparam logic        ID_START_BIT   = 1'b1;
  localparam logic [16:0] PART_CONFIG = {1'b0, on_die_termination,
    density_field, 1'b0, word_width_field, 1'b0, 1'b1, ENHANCED_GEN,
    FOUR_WORD_FAM, read_latency, BURST_OF_FOUR, on_die_termination,
    SEPARATE_IO, 1'b0};
  localparam logic [31:0] ID_VALUE = {ID_REVISION, PART_CONFIG, MAKER_CODE,
    ID_START_BIT};

  // ==========================================================================
  // tap controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sjt_state_e;

endpackage

/* File: hw/sjt_sync.sv */
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/10ps
module sjt_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import sjt_pkg::*;

  logic [WIDTH-1:0] meta_r;

  // meta_r feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

/* File: hw/sjt_tap_fsm.sv */
// tap controller state machine, one step per sampled tck rising edge
`timescale 1ns/10ps
module sjt_tap_fsm (
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          step,
  input  wire logic          tms,
  output sjt_pkg::sjt_state_e state_r
);
  import sjt_pkg::*;

  sjt_state_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (step) begin
      unique case (state_r) // [RULE_19]
        ST_RESET:  state_nxt = tms ? ST_RESET  : ST_IDLE;
        ST_IDLE:   state_nxt = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: state_nxt = tms ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // check helper: tck rises in a row with tms high, saturating at five
  logic [2:0] ones_r;
  logic [2:0] ones_nxt;

  always_comb begin
    ones_nxt = ones_r;
    if (step && tms) begin
      if (ones_r != 3'h5) begin
        ones_nxt = ones_r + 3'h1;
      end
    end else if (step) begin
      ones_nxt = 3'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ones_r <= 3'h0;
    end else begin
      ones_r <= ones_nxt;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // five ones with tms high always land in reset
  AST_FSM_FIVE_ONES: assert property ( // [RULE_19]
    ones_r == 3'h5 |-> state_r == ST_RESET)
    else $error("five tms ones did not reach reset");

  AST_FSM_HOLD: assert property ( // [RULE_19]
    !step |=> state_r == $past(state_r))
    else $error("tap state moved without a tck rising edge");

endmodule

/* File: hw/sjt_tap_top.sv */
// boundary-scan test port: instruction decode, data registers and tdo drive
`timescale 1ns/10ps
module sjt_tap_top (
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  input  wire logic                           tck,
  input  wire logic                           tms,
  input  wire logic                           tdi,
  input  wire logic [sjt_pkg::BALL_CELLS-1:0] ball_in,
  output logic                                tdo,
  output logic                                tdo_oe_b,
  output logic      [sjt_pkg::BALL_CELLS-1:0] ball_out,
  output logic                                extest_active,
  output logic                                q_bus_enable
);
  import sjt_pkg::*;

  // ==========================================================================
  // pin sampling
  logic [2:0]            pin_s;
  logic [BALL_CELLS-1:0] ball_s;
  logic                  tck_s;
  logic                  tms_s;
  logic                  tdi_s;
  logic                  tck_d_r;
  logic                  tck_d_nxt;
  logic                  rise;
  logic                  fall;

  // tck, tms and tdi share one synchroniser so they stay aligned
  sjt_sync #(.WIDTH(3)) u_pin_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   ({tck, tms, tdi}),
    .dout  (pin_s)
  );

  // ball levels may be moving at capture; only a stable value is meaningful
  sjt_sync #(.WIDTH(BALL_CELLS)) u_ball_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   (ball_in),
    .dout  (ball_s)
  );

  assign tck_s = pin_s[2];
  assign tms_s = pin_s[1];
  assign tdi_s = pin_s[0];

  always_comb begin
    tck_d_nxt = tck_s;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_d_nxt;
    end
  end

  assign rise = tck_s & ~tck_d_r;
  assign fall = ~tck_s & tck_d_r;

  // ==========================================================================
  // controller
  sjt_state_e state_r;

  sjt_tap_fsm u_fsm (
    .clock   (clock),
    .rst_b   (rst_b),
    .step    (rise),
    .tms     (tms_s),
    .state_r (state_r)
  );

  // ==========================================================================
  // instruction register
  logic [IR_LEN-1:0] ir_r;
  logic [IR_LEN-1:0] ir_nxt;
  logic [IR_LEN-1:0] ir_sh_r;
  logic [IR_LEN-1:0] ir_sh_nxt;

  always_comb begin
    ir_nxt    = ir_r;
    ir_sh_nxt = ir_sh_r;
    if (state_r == ST_RESET) begin
      ir_nxt = INS_IDCODE; // [RULE_16]
    end else if (rise && state_r == ST_CAP_IR) begin
      ir_sh_nxt = IR_CAPTURE;
    end else if (rise && state_r == ST_SH_IR) begin
      ir_sh_nxt = {tdi_s, ir_sh_r[IR_LEN-1:1]};
    end else if (fall && state_r == ST_UPD_IR) begin
      ir_nxt = ir_sh_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ir_r    <= INS_IDCODE; // [RULE_16]
      ir_sh_r <= IR_CAPTURE;
    end else begin
      ir_r    <= ir_nxt;
      ir_sh_r <= ir_sh_nxt;
    end
  end

  // ==========================================================================
  // instruction decode; reserved codes fall back to bypass as a safe path
  logic sel_bsr;
  logic sel_id;
  logic upd_ok;

  always_comb begin
    sel_bsr = 1'b0;
    sel_id  = 1'b0;
    upd_ok  = 1'b0;
    unique case (ir_r)
      INS_EXTEST: begin // [RULE_01]
        sel_bsr = 1'b1;
        upd_ok  = 1'b1;
      end
      INS_IDCODE: begin
        sel_id = 1'b1; // [RULE_02]
      end
      INS_SAMPLE_Z: begin
        sel_bsr = 1'b1; // [RULE_03]
      end
      INS_SAMPLE: begin // [RULE_04]
        sel_bsr = 1'b1;
        upd_ok  = 1'b1;
      end
      default: begin
        sel_bsr = 1'b0; // [RULE_05] [RULE_06]
      end
    endcase
  end

  // ==========================================================================
  // data registers
  logic [BSR_LEN-1:0] bsr_r;
  logic [BSR_LEN-1:0] bsr_nxt;
  logic [BSR_LEN-1:0] upd_r;
  logic [BSR_LEN-1:0] upd_nxt;
  logic [ID_LEN-1:0]  id_sh_r;
  logic [ID_LEN-1:0]  id_sh_nxt;
  logic               byp_r;
  logic               byp_nxt;

  always_comb begin
    bsr_nxt   = bsr_r;
    upd_nxt   = upd_r;
    id_sh_nxt = id_sh_r;
    byp_nxt   = byp_r;
    if (state_r == ST_RESET) begin
      upd_nxt[QEN_CELL] = QEN_RESET; // [RULE_17]
    end else if (rise && state_r == ST_CAP_DR) begin
      // unconnected-ball cells capture whatever the pad shows
      bsr_nxt   = {upd_r[QEN_CELL], ball_s}; // [RULE_14] [RULE_15]
      id_sh_nxt = ID_VALUE; // [RULE_07] [RULE_08]
      byp_nxt   = 1'b0;
    end else if (rise && state_r == ST_SH_DR) begin
      if (sel_bsr) begin
        bsr_nxt = {tdi_s, bsr_r[BSR_LEN-1:1]}; // [RULE_14]
      end else if (sel_id) begin
        id_sh_nxt = {tdi_s, id_sh_r[ID_LEN-1:1]}; // [RULE_02]
      end else begin
        byp_nxt = tdi_s; // [RULE_18]
      end
    end else if (fall && state_r == ST_UPD_DR && upd_ok) begin
      upd_nxt = bsr_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bsr_r   <= '0;
      upd_r   <= '0;
      id_sh_r <= ID_VALUE;
      byp_r   <= 1'b0;
    end else begin
      bsr_r   <= bsr_nxt;
      upd_r   <= upd_nxt;
      id_sh_r <= id_sh_nxt;
      byp_r   <= byp_nxt;
    end
  end

  assign ball_out = upd_r[BALL_CELLS-1:0];

  // ==========================================================================
  // outputs: tdo and its enable move only on tck falling edges
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_oe_b_r;
  logic tdo_oe_b_nxt;
  logic extest_r;
  logic extest_nxt;
  logic qen_r;
  logic qen_nxt;
  logic in_shift;

  assign in_shift = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);

  always_comb begin
    tdo_nxt      = tdo_r;
    tdo_oe_b_nxt = tdo_oe_b_r;
    if (fall) begin
      tdo_oe_b_nxt = ~in_shift; // [RULE_20]
      if (state_r == ST_SH_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (sel_bsr) begin
        tdo_nxt = bsr_r[0];
      end else if (sel_id) begin
        tdo_nxt = id_sh_r[0];
      end else begin
        tdo_nxt = byp_r; // [RULE_18]
      end
    end
    extest_nxt = (ir_r == INS_EXTEST);
    // float the bus in sample-z; in external test cell 109 decides
    if (ir_r == INS_EXTEST) begin
      qen_nxt = upd_r[QEN_CELL]; // [RULE_17]
    end else if (ir_r == INS_SAMPLE_Z) begin
      qen_nxt = 1'b0; // [RULE_03]
    end else begin
      qen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tdo_r      <= 1'b0;
      tdo_oe_b_r <= 1'b1;
      extest_r   <= 1'b0;
      qen_r      <= 1'b1;
    end else begin
      tdo_r      <= tdo_nxt;
      tdo_oe_b_r <= tdo_oe_b_nxt;
      extest_r   <= extest_nxt;
      qen_r      <= qen_nxt;
    end
  end

  assign tdo           = tdo_r;
  assign tdo_oe_b      = tdo_oe_b_r;
  assign extest_active = extest_r;
  assign q_bus_enable  = qen_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  AST_IR_RESET_LOAD: assert property ( // [RULE_16]
    state_r == ST_RESET |=> ir_r == INS_IDCODE)
    else $error("reset state did not load the identification code");

  AST_ID_START_BIT: assert property ( // [RULE_08]
    rise && state_r == ST_CAP_DR |=> id_sh_r[0] == 1'b1)
    else $error("identification start bit not captured as one");

  AST_ID_LAYOUT: assert property ( // [RULE_07]
    rise && state_r == ST_CAP_DR |=> id_sh_r[31:29] == ID_REVISION
      && id_sh_r[11:1] == MAKER_CODE && id_sh_r[28:12] == PART_CONFIG)
    else $error("identification fields misplaced");

  AST_ID_DENSITY: assert property ( // [RULE_09]
    rise && state_r == ST_CAP_DR |=> id_sh_r[26:24] == density_field)
    else $error("density field wrong");

  AST_ID_WIDTH: assert property ( // [RULE_10]
    rise && state_r == ST_CAP_DR |=> id_sh_r[22:21] == word_width_field)
    else $error("word width field wrong");

  AST_ID_FLAGS: assert property ( // [RULE_12]
    rise && state_r == ST_CAP_DR |=> id_sh_r[15] == BURST_OF_FOUR
      && id_sh_r[13] == SEPARATE_IO && id_sh_r[14] == on_die_termination)
    else $error("configuration flags wrong");

  AST_ID_FAMILY: assert property ( // [RULE_11] [RULE_13]
    rise && state_r == ST_CAP_DR |=> id_sh_r[16] == read_latency
      && id_sh_r[18] == ENHANCED_GEN && id_sh_r[17] == FOUR_WORD_FAM)
    else $error("latency or family flags wrong");

  AST_BYPASS_ONE_STAGE: assert property ( // [RULE_18]
    rise && state_r == ST_SH_DR && ir_r == INS_BYPASS
      |=> byp_r == $past(tdi_s))
    else $error("bypass stage did not take tdi");

  AST_EXTEST_PATH: assert property ( // [RULE_01]
    fall && state_r == ST_SH_DR && ir_r == INS_EXTEST
      |=> tdo_r == $past(bsr_r[0]) ##0 !tdo_oe_b_r)
    else $error("external test did not shift the chain");

  AST_SAMPLE_PATH: assert property ( // [RULE_04]
    fall && state_r == ST_SH_DR && ir_r == INS_SAMPLE
      |=> tdo_r == $past(bsr_r[0]))
    else $error("sample did not shift the chain");

  AST_ID_PATH: assert property ( // [RULE_02]
    fall && state_r == ST_SH_DR && ir_r == INS_IDCODE
      |=> tdo_r == $past(id_sh_r[0]))
    else $error("identification register not on tdo");

  AST_QBUS_EXTEST: assert property ( // [RULE_17]
    (ir_r == INS_EXTEST)[*2] |-> q_bus_enable == $past(upd_r[QEN_CELL]))
    else $error("cell 109 does not steer the data bus");

  AST_SAMPLEZ_FLOAT: assert property ( // [RULE_03]
    ir_r == INS_SAMPLE_Z |=> !q_bus_enable)
    else $error("output bus not floated in sample-z");

  AST_TDO_ON_FALL: assert property ( // [RULE_20]
    !fall |=> $stable(tdo_r) && $stable(tdo_oe_b_r))
    else $error("tdo moved away from a tck falling edge");

  AST_TDO_OE_SHIFT: assert property ( // [RULE_20]
    fall |=> tdo_oe_b_r == !($past(in_shift)))
    else $error("tdo enable does not follow shift states");

endmodule

/* File: verification/sjt_jtag_host.sv */
// tester model that drives the serial test port and samples tdo
`timescale 1ns/10ps
module sjt_jtag_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe_b
);
  import sjt_pkg::*;
  // ==========================================================================
  // link timing
  // 125 ns period; tck rests low between frames
  localparam realtime HALF = 62.5;
  logic oe_ok;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_ok = 1'b1;
  end

  // ==========================================================================
  // one tck cycle: tms/tdi move just after the fall, tdo taken before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(HALF);
    q = tdo;
    tck = 1'b1;
    #(HALF);
    tck = 1'b0;
  endtask

  // five rises with tms high always land in test-logic-reset
  task automatic reset_tap();
    logic q;
    #2;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // reserved codes go out like any other; the main sequence sends 3, 5 and 6 and expects bypass
  task automatic shift_ir(input logic [2:0] code, output logic [2:0] cap);
    logic q;
    #2;
    step(1'b1, 1'b0, q);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < IR_LEN; i++) begin
      step(i == IR_LEN - 1, code[i], q);
      cap[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // always shifts the full chain length, so the path length shows in dout
  task automatic shift_dr(input logic [BSR_LEN-1:0] din,
                          output logic [BSR_LEN-1:0] dout);
    logic q;
    #2;
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    oe_ok = 1'b1;
    for (int i = 0; i < BSR_LEN; i++) begin
      step(i == BSR_LEN - 1, din[i], q);
      dout[i] = q;
      if (tdo_oe_b !== 1'b0) begin
        oe_ok = 1'b0;
      end
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

/* File: verification/sjt_tap_top_tb_top.sv */
// testbench for the boundary-scan test port
`timescale 1ns/10ps
module sjt_tap_top_tb_top;
  import sjt_pkg::*;
  localparam int W = BSR_LEN;
  logic                  clock, rst_b, tck, tms, tdi, tdo, tdo_oe_b;
  logic                  extest_active, q_bus_enable, latch;
  logic [BALL_CELLS-1:0] ball_in, ball_out, exp_ball;
  logic [ID_LEN-1:0]     id_exp;
  logic [2:0]            ir_cap;
  logic [2:0]            codes [9];
  int                    n_errors, checked;

  // cells of unconnected balls are not modelled; all cells compared
  assign id_exp = {3'h0, 1'b0, 1'b0, 3'h1, 1'b0, 2'h3, 2'b01, 1'b1, 1'b0,
                   1'b0, 1'b1, 1'b0, 1'b0, 1'b0, MAKER_CODE, 1'b1};

  sjt_tap_top i_dut (
    .clock         (clock),
    .rst_b         (rst_b),
    .tck           (tck),
    .tms           (tms),
    .tdi           (tdi),
    .ball_in       (ball_in),
    .tdo           (tdo),
    .tdo_oe_b      (tdo_oe_b),
    .ball_out      (ball_out),
    .extest_active (extest_active),
    .q_bus_enable  (q_bus_enable)
  );

  sjt_jtag_host i_host (
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .tdo      (tdo),
    .tdo_oe_b (tdo_oe_b)
  );

  always #5 clock = ~clock;

  // ==========================================================================
  // helpers
  task automatic check(input logic [W-1:0] got, input logic [W-1:0] want,
                       input string what);
    checked++;
    if (got !== want) begin
      $display("wrong value at %0t: %s", $time, what);
      n_errors++;
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // shifts d through the selected path and checks capture, path and update
  task automatic run_dr(input logic [2:0] c, input logic [W-1:0] d);
    logic [W-1:0] got, cap;
    logic         qe;
    int           len;
    len = 1;
    cap = '0;
    if (c == 3'h1) begin
      len = ID_LEN;
      cap = W'(id_exp);
    end
    if (c == 3'h0 || c == 3'h2 || c == 3'h4) begin
      len = W;
      cap = {latch, ball_in};
    end
    @(negedge clock);
    i_host.shift_dr(d, got);
    check(got, (d << len) | cap, "serial path");
    check(W'(i_host.oe_ok), W'(1), "tdo enable in shift");
    if (c == 3'h0 || c == 3'h4) begin
      latch = d[W-1];
      exp_ball = d[BALL_CELLS-1:0];
    end
    qe = (c == 3'h0) ? latch : (c == 3'h2) ? 1'b0 : 1'b1;
    repeat (5) @(negedge clock);
    check(W'(ball_out), W'(exp_ball), "ball update");
    check(W'(q_bus_enable), W'(qe), "bus enable");
    check(W'(extest_active), W'(c == 3'h0), "extest flag");
    check(W'(tdo_oe_b), W'(1), "tdo released");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    ball_in = '0;
    exp_ball = '0;
    latch = 1'b0;
    n_errors = 0;
    checked = 0;
    codes = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h7, 3'h3, 3'h5, 3'h6, 3'h0};
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    check(W'(tdo_oe_b), W'(1), "tdo after reset");
    check(W'(ball_out), W'(0), "balls after reset");
    check(W'(q_bus_enable), W'(1), "bus after reset");
    $display("test reset values done");
    i_host.reset_tap();
    run_dr(3'h1, {1'b1, {27{4'ha}}});
    $display("test identification after reset done");
    for (int k = 0; k < 9; k++) begin
      @(negedge clock);
      ball_in = {27{4'(k) + 4'h9}};
      i_host.shift_ir(codes[k], ir_cap);
      check(W'(ir_cap), W'(3'h1), "instruction capture");
      run_dr(codes[k], {~k[0], {27{4'(k) ^ 4'h5}}});
      $display("test instruction %0d done", codes[k]);
    end
    // latch was left high, so a floating bus shows the reset took effect
    @(negedge clock);
    i_host.reset_tap();
    repeat (5) @(negedge clock);
    check(W'(extest_active), W'(0), "extest after tap reset");
    latch = 1'b0;
    run_dr(3'h1, {1'b0, {27{4'h3}}});
    @(negedge clock);
    i_host.shift_ir(3'h0, ir_cap);
    repeat (5) @(negedge clock);
    check(W'(q_bus_enable), W'(0), "bus floats after tap reset");
    $display("test tap reset done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clock);
    $display("wrong value at %0t: run did not finish", $time);
    n_errors++;
    finish_test();
  end
endmodule
